// >>> common/pwm_pkg.sv
// Package for the 8-bit sub-cycle pulse width modulator.
// Assumes one 10 MHz clock domain and an AHB-Lite master with word accesses.
package pwm_pkg;

    // Register byte addresses.
    localparam logic [7:0] PWM_OFS_DUTY = 8'h00;
    localparam logic [7:0] PWM_OFS_CTRL = 8'h04;
    localparam logic [7:0] PWM_OFS_DIR = 8'h08;
    localparam logic [7:0] PWM_OFS_DATA = 8'h0C;
    localparam logic [7:0] PWM_OFS_PULL = 8'h10;
    localparam logic [7:0] PWM_OFS_STAT = 8'h14;

    // Field positions.
    localparam int PWM_BIT_SEL = 3;
    localparam int PWM_BIT_MODE = 5;
    localparam int PWM_BIT_PIN = 4;

    // Reset values.
    localparam logic [7:0] PWM_RST_DUTY = 8'h00;
    localparam logic PWM_RST_DIR = 1'b1;

    // Timing counts in modulator clocks.
    localparam logic [7:0] PWM_CNT_LAST = 8'hFF;
    localparam int PWM_PERIOD = 256;
    localparam int PWM_SUB4_LEN = 64;
    localparam int PWM_SUB2_LEN = 128;

    // Bus request from the master.
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } pwm_ahb_req_t;

    // Bus answer to the master.
    typedef struct packed {
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } pwm_ahb_rsp_t;

    // Shared pin as driven by the block.
    typedef struct packed {
        logic pin_o;
        logic pin_oe;
        logic pull_en;
    } pwm_pin_t;

endpackage

// >>> rtl/pwm_modulator.sv
// Sub-cycle pulse width modulator with AHB-Lite registers and shared pin control.
// Assumes a 10 MHz clk, an active-low asynchronous rstn and a single-slave AHB-Lite bus.
`timescale 1ns/100ps

module pwm_modulator
    import pwm_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire pwm_ahb_req_t ahb_req,
    output pwm_ahb_rsp_t ahb_rsp,
    input wire logic pin_i,
    output pwm_pin_t pin
);

    // Whole state of the block in one record.
    typedef struct packed {
        logic [7:0] cnt;
        logic [7:0] duty;
        logic sel;
        logic mode2;
        logic [7:0] act_duty;
        logic act_mode2;
        logic dir;
        logic data;
        logic pull;
        logic [2:0] sync;
        logic pin_lvl;
        logic wr_pend;
        logic [7:0] waddr;
        pwm_ahb_rsp_t rsp;
        pwm_pin_t pin;
    } pwm_state_t;

    pwm_state_t s_q;
    pwm_state_t s_d;
    logic lvl;

    // Waveform level for one count, duty and mode; sub-cycle split happens here.
    function automatic logic pwm_level(logic [7:0] cnt, logic [7:0] duty, logic two);
        logic [7:0] pos;
        logic [7:0] base;
        logic bump;
        pos = 8'h00;
        base = 8'h00;
        bump = 1'b0;
        if (two) begin
            pos = {1'b0, cnt[6:0]};
            base = {1'b0, duty[7:1]};
            bump = ({1'b0, cnt[7]} < {1'b0, duty[0]});
        end else begin
            pos = {2'b00, cnt[5:0]};
            base = {2'b00, duty[7:2]};
            bump = (cnt[7:6] < duty[1:0]);
        end
        return (pos < (8'(base + {7'h00, bump}))) || (bump && (pos == base));
    endfunction

    // Read mux over the register map; unmapped words read as zero.
    function automatic logic [31:0] pwm_read(logic [7:0] a, pwm_state_t s);
        logic [31:0] r;
        r = 32'h0000_0000;
        unique case (a)
            PWM_OFS_DUTY: r[7:0] = s.duty;
            PWM_OFS_CTRL: begin
                r[PWM_BIT_SEL] = s.sel;
                r[PWM_BIT_MODE] = s.mode2;
            end
            PWM_OFS_DIR: r[PWM_BIT_PIN] = s.dir;
            PWM_OFS_DATA: r[PWM_BIT_PIN] = s.data;
            PWM_OFS_PULL: r[PWM_BIT_PIN] = s.pull;
            PWM_OFS_STAT: r = {13'h0000, s.pin.pin_oe, s.pin_lvl, s.act_mode2,
                               s.act_duty, s.cnt};
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // Level of the current count from the duty latched for this period.
    assign lvl = pwm_level(s_q.cnt, s_q.act_duty, s_q.act_mode2);

    // Next-state logic for counter, registers, pin and bus.
    always_comb begin
        s_d = s_q;
        s_d.cnt = 8'(s_q.cnt + 8'h01);
        if (s_q.cnt == PWM_CNT_LAST) begin
            s_d.act_duty = s_q.duty;
            s_d.act_mode2 = s_q.mode2;
        end
        // Three-stage synchroniser; the level moves only when stages two and three agree.
        s_d.sync = {s_q.sync[1:0], pin_i};
        if (s_q.sync[1] == s_q.sync[2]) begin
            s_d.pin_lvl = s_q.sync[2];
        end
        if (s_q.sel) begin
            s_d.pin.pin_oe = !s_q.dir;
            s_d.pin.pin_o = !s_q.dir && s_q.data && lvl;
        end else begin
            s_d.pin.pin_oe = !s_q.dir;
            s_d.pin.pin_o = !s_q.dir && s_q.data;
        end
        // pull-high only while the pin is an input
        s_d.pin.pull_en = s_q.dir && s_q.pull;
        // Data phase of a write: the byte captured in the address phase selects the target.
        // software writes only values
        s_d.wr_pend = 1'b0;
        if (s_q.wr_pend) begin
            unique case (s_q.waddr)
                PWM_OFS_DUTY: s_d.duty = ahb_req.hwdata[7:0];
                PWM_OFS_CTRL: begin
                    s_d.sel = ahb_req.hwdata[PWM_BIT_SEL];
                    s_d.mode2 = ahb_req.hwdata[PWM_BIT_MODE];
                end
                PWM_OFS_DIR: s_d.dir = ahb_req.hwdata[PWM_BIT_PIN];
                PWM_OFS_DATA: s_d.data = ahb_req.hwdata[PWM_BIT_PIN];
                PWM_OFS_PULL: s_d.pull = ahb_req.hwdata[PWM_BIT_PIN];
                default: s_d.wr_pend = 1'b0;
            endcase
        end
        // Address phase; zero wait states so reads are loaded now for the next cycle.
        if (ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1]) begin
            s_d.waddr = ahb_req.haddr[7:0];
            s_d.wr_pend = ahb_req.hwrite && (ahb_req.haddr[31:8] == 24'h000000);
            if (!ahb_req.hwrite) begin
                s_d.rsp.hrdata = (ahb_req.haddr[31:8] == 24'h000000) ?
                    pwm_read(ahb_req.haddr[7:0], s_q) : 32'h0000_0000;
            end
        end
        s_d.rsp.hreadyout = 1'b1;
        s_d.rsp.hresp = 1'b0;
    end

    // State register; a low clock enable freezes everything.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.duty <= PWM_RST_DUTY;
            s_q.act_duty <= PWM_RST_DUTY;
            s_q.dir <= PWM_RST_DIR;
            s_q.rsp.hreadyout <= 1'b1;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign ahb_rsp = s_q.rsp;
    assign pin = s_q.pin;

    // Helper: high clocks seen so far in the running period.
    logic [8:0] hi_cnt_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hi_cnt_q <= 9'h000;
        end else if (ce) begin
            if (s_q.cnt == PWM_CNT_LAST) begin
                hi_cnt_q <= 9'h000;
            end else begin
                hi_cnt_q <= 9'(hi_cnt_q + {8'h00, lvl});
            end
        end
    end

    // Counter advances by one on each enabled clock.
    property p_cnt_step;
        @(posedge clk) disable iff (!rstn)
        ce |=> (s_q.cnt == 8'($past(s_q.cnt) + 8'h01));
    endproperty
    a_cnt_step: assert property (p_cnt_step)
        else $error("period counter did not advance by one");

    // Total high time over one period equals the latched duty.
    property p_period_duty;
        @(posedge clk) disable iff (!rstn)
        (ce && s_q.cnt == PWM_CNT_LAST) |->
            (9'(hi_cnt_q + {8'h00, lvl}) == {1'b0, s_q.act_duty});
    endproperty
    a_period_duty: assert property (p_period_duty)
        else $error("high clocks in period differ from duty");

    // Active duty changes only across a period boundary.
    property p_latch_edge;
        @(posedge clk) disable iff (!rstn)
        (s_q.act_duty != $past(s_q.act_duty)) |->
            ($past(s_q.cnt) == PWM_CNT_LAST && $past(ce));
    endproperty
    a_latch_edge: assert property (p_latch_edge)
        else $error("duty changed inside a period");

    // Waveform rises only on the first clock of a sub-cycle.
    property p_rise_start;
        @(posedge clk) disable iff (!rstn)
        (ce && !lvl) |=> (!lvl || (s_q.act_mode2 ? s_q.cnt[6:0] == 7'h00
                                                  : s_q.cnt[5:0] == 6'h00));
    endproperty
    a_rise_start: assert property (p_rise_start)
        else $error("waveform rose inside a sub-cycle");

    // Four-way mode: a sub-cycle at or above extra is low at position base.
    property p_four_base;
        @(posedge clk) disable iff (!rstn)
        (!s_q.act_mode2 && s_q.cnt[5:0] == s_q.act_duty[7:2] &&
         s_q.cnt[7:6] >= s_q.act_duty[1:0]) |-> !lvl;
    endproperty
    a_four_base: assert property (p_four_base)
        else $error("four-way sub-cycle too long");

    // Two-way mode: a sub-cycle below extra is still high at position base.
    property p_two_extra;
        @(posedge clk) disable iff (!rstn)
        (s_q.act_mode2 && s_q.cnt[6:0] == s_q.act_duty[7:1] &&
         !s_q.cnt[7] && s_q.act_duty[0]) |-> lvl;
    endproperty
    a_two_extra: assert property (p_two_extra)
        else $error("two-way sub-cycle missing extra clock");

    // Pin high only when selected or plain port drives it with data one and output.
    property p_drive_gate;
        @(posedge clk) disable iff (!rstn)
        ($past(ce) && pin.pin_o) |->
            (pin.pin_oe && $past(s_q.data) && !$past(s_q.dir));
    endproperty
    a_drive_gate: assert property (p_drive_gate)
        else $error("pin driven high without enables");

    // Data bit zero with the function selected holds the pin low.
    property p_data_off;
        @(posedge clk) disable iff (!rstn)
        (ce && s_q.sel && !s_q.data) |=> !pin.pin_o;
    endproperty
    a_data_off: assert property (p_data_off)
        else $error("pin not forced low by data bit");

    // Direction one leaves the pin undriven.
    property p_dir_input;
        @(posedge clk) disable iff (!rstn)
        (ce && s_q.sel && s_q.dir) |=> (!pin.pin_oe && pin.pull_en == $past(s_q.pull));
    endproperty
    a_dir_input: assert property (p_dir_input)
        else $error("pin driven while set as input");

    // Main scenarios.
    c_two_mode: cover property (@(posedge clk) disable iff (!rstn)
        s_q.act_mode2 && s_q.act_duty[0] && lvl);
    c_four_mode: cover property (@(posedge clk) disable iff (!rstn)
        !s_q.act_mode2 && s_q.act_duty[1:0] == 2'h3 && pin.pin_o);
    c_relatch: cover property (@(posedge clk) disable iff (!rstn)
        ce && s_q.cnt == PWM_CNT_LAST && s_q.duty != s_q.act_duty);

endmodule

// >>> verif/pwm_load_model.sv
// External load on the shared pin, such as a motor driver input stage.
// Assumes the bench decides when the load drives the pin and with what level.
`timescale 1ns/100ps
module pwm_load_model
    import pwm_pkg::*;
(
    input wire logic clk,
    input wire pwm_pin_t pin,
    input wire logic drv_en,
    input wire logic drv_val,
    output logic level
);
    logic last_q = 1'b0;
    // Resolve the wire; a floating line toggles so a stale value never passes.
    always_comb begin
        if (pin.pin_oe)
            level = pin.pin_o;
        else if (drv_en)
            level = drv_val;
        else if (pin.pull_en)
            level = 1'b1;
        else
            level = ~last_q;
    end
    // Keep the last level for the floating pattern.
    always_ff @(posedge clk) begin
        last_q <= level;
    end
endmodule

// >>> verif/pwm_8bit_subcycle_modulator_tb_top.sv
// Self-checking bench for the sub-cycle modulator with a cycle-level model.
// Assumes a zero-wait AHB-Lite slave and a status word that shows the counter.
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
    $display("unexpected %s: expected %h seen %h", nm, exp, got); end end
module pwm_8bit_subcycle_modulator_tb_top
    import pwm_pkg::*;
;
    logic clk, rstn, ce, drv_en, drv_val, pin_lvl, sw_mode, chk_en;
    logic [7:0] sw_duty;
    logic [8:0] cur, p1, lat;
    pwm_ahb_req_t req, bus_req;
    pwm_ahb_rsp_t rsp;
    pwm_pin_t pin;
    int num_errors, n_compared, ph;

    pwm_modulator i_dut (.clk(clk), .rstn(rstn), .ce(ce), .ahb_req(bus_req),
        .ahb_rsp(rsp), .pin_i(pin_lvl), .pin(pin));
    pwm_load_model i_load (.clk(clk), .pin(pin), .drv_en(drv_en), .drv_val(drv_val),
        .level(pin_lvl));

    // The single slave's answer is the bus ready.
    always_comb begin
        bus_req = req;
        bus_req.hready = rsp.hreadyout;
    end

    // Free-running 10 MHz clock.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Expected level of counter position c for a latched mode and duty.
    function automatic logic lvl(int c, logic [8:0] dm);
        int len, base, ex;
        len = dm[8] ? PWM_SUB2_LEN : PWM_SUB4_LEN;
        base = dm[8] ? int'(dm[7:1]) : int'(dm[7:2]);
        ex = dm[8] ? int'(dm[0]) : int'(dm[1:0]);
        return (c % len) < base + int'((c / len) < ex);
    endfunction

    task automatic give_verdict();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One single transfer; each phase waits for ready under a bound.
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
        output logic [31:0] rd);
        int k;
        req.hsel <= 1'b1;
        req.haddr <= {24'h0, a};
        req.htrans <= 2'b10;
        req.hwrite <= w;
        k = 0;
        do begin @(posedge clk); k++; end while (rsp.hreadyout !== 1'b1 && k < 50);
        req.hsel <= 1'b0;
        req.htrans <= 2'b00;
        req.hwdata <= wd;
        do begin @(posedge clk); k++; end while (rsp.hreadyout !== 1'b1 && k < 100);
        rd = rsp.hrdata;
        if (k >= 100) begin
            num_errors++;
            give_verdict();
        end
    endtask

    // Writes also update the software view that the model latches from.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        bus(a, 1'b1, d, rd);
        if (a == PWM_OFS_DUTY) sw_duty = d[7:0];
        if (a == PWM_OFS_CTRL) sw_mode = d[PWM_BIT_MODE];
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        bus(a, 1'b0, 32'h0, rd);
        `CHK("read data", exp, rd)
        `CHK("hresp", 1'b0, rsp.hresp)
    endtask

    // Cycle model: duty and mode latch at period start, pin shows it a clock later.
    initial begin
        forever begin
            p1 = cur;
            cur = {sw_mode, sw_duty};
            @(posedge clk);
            #1;
            ph = (ph + 1) % PWM_PERIOD;
            if (ph == 0) lat = p1;
            if (chk_en) `CHK("pin_o", lvl(ph, lat), pin.pin_o)
        end
    end

    // Watchdog so that a hang still reaches the verdict.
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        give_verdict();
    end

    initial begin
        logic [31:0] rd;
        logic [7:0] tbl [4] = '{8'h00, 8'hFF, 8'h01, 8'h7E};
        rstn = 1'b0;
        ce = 1'b1;
        req = '0;
        req.hsize = 3'b010;
        {drv_en, drv_val, sw_mode, chk_en} = 4'h0;
        {sw_duty, cur, lat, ph, num_errors, n_compared} = '0;
        void'($urandom(32'h53BC));
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd_chk(PWM_OFS_DUTY, 32'h0);
        rd_chk(PWM_OFS_DIR, 32'h10);
        wr(8'h18, 32'hFF);
        rd_chk(8'h18, 32'h0);
        // Software selects the function, output direction and data one.
        wr(PWM_OFS_DIR, 32'h0);
        wr(PWM_OFS_DATA, 32'h10);
        wr(PWM_OFS_CTRL, 32'h8);
        bus(PWM_OFS_STAT, 1'b0, 32'h0, rd);
        ph = int'(rd[7:0]);
        `CHK("status oe", 1'b1, rd[18])
        repeat (4) @(posedge clk);
        chk_en = 1'b1;
        // Both modes, boundary and random duties, written at odd moments.
        for (int m = 0; m < 2; m++) begin
            wr(PWM_OFS_CTRL, 32'h8 | (32'(m) << PWM_BIT_MODE));
            for (int j = 0; j < 6; j++) begin
                wr(PWM_OFS_DUTY, (j < 4) ? 32'(tbl[j]) : 32'($urandom_range(255)));
                repeat (300 + 37 * j) @(posedge clk);
            end
        end
        chk_en = 1'b0;
        wr(PWM_OFS_DATA, 32'h0);
        repeat (3) @(posedge clk);
        `CHK("forced low", 1'b0, pin.pin_o)
        `CHK("driving", 1'b1, pin.pin_oe)
        wr(PWM_OFS_CTRL, 32'h0);
        wr(PWM_OFS_DATA, 32'h10);
        repeat (3) @(posedge clk);
        `CHK("plain port", 1'b1, pin.pin_o)
        // Selected but set as input: pin reads as a normal input with pull-high.
        wr(PWM_OFS_CTRL, 32'h8);
        wr(PWM_OFS_DIR, 32'h10);
        wr(PWM_OFS_PULL, 32'h10);
        drv_en <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK("released", 1'b0, pin.pin_oe)
        `CHK("pull", 1'b1, pin.pull_en)
        bus(PWM_OFS_STAT, 1'b0, 32'h0, rd);
        `CHK("input low", 1'b0, rd[17])
        drv_val <= 1'b1;
        repeat (6) @(posedge clk);
        bus(PWM_OFS_STAT, 1'b0, 32'h0, rd);
        `CHK("input high", 1'b1, rd[17])
        give_verdict();
    end
endmodule
